// File: pkg/auxc_consts.vh
// Constants for the auxiliary control register and external bus timing
// Functional notes
// - Register at SFR address 8e, not bit addressable, low five bits reset to zero.
// - wdt_idle_halt set stops watchdog counting in idle; clear keeps it counting.
// - reset_out_disable clear lets watchdog reset drive pin at reset_polarity; set: input only.
// - Fast mode: waits 0..3, strobe 1,2,2,3 cycles, latch setup 1,1,2,2 cycles.
// - Compatibility: strobe 3 or 15 cycles, latch setup 1.5 cycles in the table, run as 1 cycle.
// - Upper wait bit forced to zero in compatibility mode.
// - external_ram_only set sends every external move to the external bus.
// - Latch strobe free-runs at clock/3 compatibility, clock/2 fast, when enabled.
// - ale_idle_disable set holds latch strobe high except during external accesses.
// - Bits 4 and 3 act as watchdog controls only in compatibility mode.
// - Full address held stable on both ports at latch strobe falling edge.
// - Nonzero wait settings lengthen read and write strobes by 1, 1 or 2 cycles in fast mode, by 12 in compatibility when bit 2 is set.
`ifndef AUXC_CONSTS_VH
`define AUXC_CONSTS_VH
`define AUXC_SFR_ADDR      8'h8e
`define AUXC_RESET         8'h00
`define AUXC_BIT_ALE_DIS   0
`define AUXC_BIT_EXTERNAL_RAM_ONLY     1
`define AUXC_BIT_WS_LO     2
`define AUXC_BIT_WS_HI     3
`define AUXC_BIT_IDLE_HALT 4
`define AUXC_DEF_MASK      8'h1f
`define AUXC_TOP_READ      3'h0
`define AUXC_CMP_STROBE    4'h3
`define AUXC_CMP_STROBE_W1 4'hf
`define AUXC_CMP_SETUP_H   4'h3
`define AUXC_ALE_DIV_FAST  2'h2
`define AUXC_ALE_DIV_CMP   2'h3
`define AUXC_INT_TOP       16'h00ff
`endif

// File: core/auxc_ale_gen.v
// Free-running address latch strobe divider
`timescale 1ns/100ps
`include "auxc_consts.vh"
module auxc_ale_gen (
  input  wire       i_clock,    // System clock
  input  wire       i_rst_n,    // Sync reset, active low
  input  wire       i_ce,       // Clock enable
  input  wire       i_fast,     // Fast mode
  output reg        o_tick      // One-cycle pulse at clock/2 or clock/3
);
  reg  [1:0] cnt_q;
  wire [1:0] div = i_fast ? `AUXC_ALE_DIV_FAST : `AUXC_ALE_DIV_CMP;
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      // Start one step in, so the first free pulse after reset comes one cycle sooner than the steady rate
      cnt_q  <= 2'h1;
      o_tick <= 1'b0;
    end else if (i_ce) begin
      if (cnt_q >= div - 2'h1) begin
        cnt_q  <= 2'h0;
        o_tick <= 1'b1;
      end else begin
        cnt_q  <= cnt_q + 2'h1;
        o_tick <= 1'b0;
      end
    end
  end
endmodule // auxc_ale_gen

// File: core/auxc_sync2.v
// Two-flop synchroniser for a pin level
`timescale 1ns/100ps
module auxc_sync2 (
  input  wire i_clock,   // System clock
  input  wire i_rst_n,   // Sync reset, active low
  input  wire i_ce,      // Clock enable
  input  wire i_async,   // Asynchronous input
  output reg  o_sync     // Synchronised level
);
  reg meta_q;
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      meta_q <= 1'b0;
      o_sync <= 1'b0;
    end else if (i_ce) begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule // auxc_sync2

// File: core/auxc_top.v
// Auxiliary control register and external data bus sequencer
`timescale 1ns/100ps
`include "auxc_consts.vh"
module auxc_top (
  input  wire        i_clock,          // 100 MHz system clock
  input  wire        i_rst_n,          // Sync reset, active low
  input  wire        i_ce,             // Clock enable, freezes all state when low
  input  wire        i_fast,           // 1 = fast mode, 0 = compatibility mode
  input  wire [7:0]  i_sfr_addr,       // SFR address
  input  wire        i_sfr_wr,         // SFR write strobe
  input  wire        i_sfr_rd,         // SFR read strobe
  input  wire [7:0]  i_sfr_wdata,      // SFR write data
  output reg  [7:0]  o_sfr_rdata,      // SFR read data
  output wire        o_sfr_hit,        // Address decodes to this register
  input  wire        i_watchdog_control_reg_idle,    // Idle halt bit from watchdog control reg
  input  wire        i_watchdog_control_reg_rstdis,  // Reset out disable from watchdog control reg
  input  wire        i_idle,           // Core in idle
  input  wire        i_wdt_reset,      // Watchdog reset pulse
  input  wire        i_reset_polarity, // Reset pin active level
  output wire        o_wdt_count_en,   // Watchdog counter may count
  output reg         o_rst_pin_out,    // Reset pin drive value
  output reg         o_rst_pin_oe_n,   // Reset pin enable, low = drive
  input  wire        i_xreq,           // External move request pulse
  input  wire        i_xwrite,         // 1 = write, 0 = read
  input  wire [15:0] i_xaddr,          // External move address
  input  wire [7:0]  i_xwdata,         // Write data
  output reg  [7:0]  o_xrdata,         // Read data
  output wire        o_xbusy,          // Transfer in progress
  output reg         o_xdone,          // One-cycle done pulse
  output wire        o_xinternal,      // Request served by internal memory
  output reg  [7:0]  o_p2_out,         // Upper address port
  output reg  [7:0]  o_p0_out,         // Low address / data port
  output reg         o_p0_oe_n,        // Port 0 enable, low = drive
  input  wire [7:0]  i_p0_in,          // Port 0 pin inputs
  output reg         o_ale,            // Address latch strobe
  output reg         o_rd_n,           // Read strobe, active low
  output reg         o_wr_n            // Write strobe, active low
);
  ////////////////////////////////////////////////////////////////////////////
  // Register
  reg  [4:0] aux_q;
  localparam [7:0] AUX_RST = `AUXC_RESET;
  wire       ale_dis   = aux_q[`AUXC_BIT_ALE_DIS];
  wire       ext_only  = aux_q[`AUXC_BIT_EXTERNAL_RAM_ONLY];
  wire       ws_lo     = aux_q[`AUXC_BIT_WS_LO];
  wire       ws_hi     = i_fast & aux_q[`AUXC_BIT_WS_HI];
  wire [1:0] wait_sel  = {ws_hi, ws_lo};
  wire       idle_halt = i_fast ? i_watchdog_control_reg_idle : aux_q[`AUXC_BIT_IDLE_HALT];
  wire       rst_dis   = i_fast ? i_watchdog_control_reg_rstdis : aux_q[`AUXC_BIT_WS_HI];

  assign o_sfr_hit = (i_sfr_addr == `AUXC_SFR_ADDR);

  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      aux_q <= AUX_RST[4:0];
    end else if (i_ce && i_sfr_wr && o_sfr_hit) begin
      aux_q <= i_sfr_wdata[4:0];
    end
  end

  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_ce && i_sfr_rd) begin
      o_sfr_rdata <= o_sfr_hit ? {`AUXC_TOP_READ, aux_q} : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog options
  assign o_wdt_count_en = !(i_idle && idle_halt);

  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_rst_pin_out  <= 1'b0;
      o_rst_pin_oe_n <= 1'b1;
    end else if (i_ce) begin
      o_rst_pin_out  <= i_reset_polarity;
      o_rst_pin_oe_n <= !(i_wdt_reset && !rst_dis);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timing tables
  function [3:0] strobe_len;
    input       fast;
    input [1:0] ws;
    begin
      if (fast) begin
        case (ws)
          2'h0:    strobe_len = 4'h1;
          2'h1:    strobe_len = 4'h2;
          2'h2:    strobe_len = 4'h2;
          default: strobe_len = 4'h3;
        endcase
      end else begin
        strobe_len = ws[0] ? `AUXC_CMP_STROBE_W1 : `AUXC_CMP_STROBE;
      end
    end
  endfunction

  // Setup counted in half cycles, then halved with truncation, so the 1.5 cycle figure runs as 1
  function [3:0] setup_half;
    input       fast;
    input [1:0] ws;
    begin
      if (fast) begin
        setup_half = ws[1] ? 4'h4 : 4'h2;
      end else begin
        setup_half = `AUXC_CMP_SETUP_H;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Free-running latch strobe
  wire ale_tick;
  auxc_ale_gen u_ale (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_fast  (i_fast),
    .o_tick  (ale_tick)
  );

  wire [7:0] p0_sync;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_p0sync
      auxc_sync2 u_sync (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_async (i_p0_in[g]),
        .o_sync  (p0_sync[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // External access sequencer
  localparam ST_IDLE  = 3'h0;
  localparam ST_ALE   = 3'h1;
  localparam ST_SETUP = 3'h2;
  localparam ST_STRB  = 3'h3;
  localparam ST_HOLD  = 3'h4;

  reg [2:0]  state_q;
  reg [3:0]  cnt_q;
  reg        wr_q;
  reg [7:0]  wdata_q;
  reg [15:0] addr_q;

  wire is_int = !ext_only && (i_xaddr <= `AUXC_INT_TOP);
  assign o_xinternal = i_xreq && is_int;
  assign o_xbusy     = (state_q != ST_IDLE);
  wire   start       = i_xreq && !is_int && !o_xbusy;

  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_q   <= ST_IDLE;
      cnt_q     <= 4'h0;
      wr_q      <= 1'b0;
      wdata_q   <= 8'h00;
      addr_q    <= 16'h0000;
      o_xrdata  <= 8'h00;
      o_xdone   <= 1'b0;
      o_p2_out  <= 8'h00;
      o_p0_out  <= 8'h00;
      o_p0_oe_n <= 1'b1;
      o_ale     <= 1'b1;
      o_rd_n    <= 1'b1;
      o_wr_n    <= 1'b1;
    end else if (i_ce) begin
      o_xdone <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          o_rd_n    <= 1'b1;
          o_wr_n    <= 1'b1;
          o_p0_oe_n <= 1'b1;
          o_ale     <= ale_dis ? 1'b1 : ale_tick;
          if (start) begin
            addr_q    <= i_xaddr;
            wr_q      <= i_xwrite;
            wdata_q   <= i_xwdata;
            o_p2_out  <= i_xaddr[15:8];
            o_p0_out  <= i_xaddr[7:0];
            o_p0_oe_n <= 1'b0;
            o_ale     <= 1'b1;
            state_q   <= ST_ALE;
          end
        end
        ST_ALE: begin
          o_ale   <= 1'b0;
          cnt_q   <= setup_half(i_fast, wait_sel) >> 1;
          state_q <= ST_SETUP;
        end
        ST_SETUP: begin
          if (cnt_q <= 4'h1) begin
            if (wr_q) begin
              o_p0_out <= wdata_q;
              o_wr_n   <= 1'b0;
            end else begin
              o_p0_oe_n <= 1'b1;
              o_rd_n    <= 1'b0;
            end
            cnt_q   <= strobe_len(i_fast, wait_sel);
            state_q <= ST_STRB;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ST_STRB: begin
          if (cnt_q <= 4'h1) begin
            o_rd_n   <= 1'b1;
            o_wr_n   <= 1'b1;
            cnt_q    <= wr_q ? 4'h0 : 4'h1;
            state_q  <= ST_HOLD;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        // Read data reaches us through the two-flop pin synchroniser, so let it drain
        ST_HOLD: begin
          o_p0_oe_n <= 1'b1;
          if (cnt_q == 4'h0) begin
            o_xrdata <= wr_q ? o_xrdata : p0_sync;
            o_xdone  <= 1'b1;
            state_q  <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // auxc_top

// File: verification/auxc_sram_model.sv
// External SRAM with address latch on the multiplexed bus
`timescale 1ns/100ps
module auxc_sram_model (
  input  wire       i_clock, // System clock
  input  wire [7:0] i_p2,    // Upper address
  input  wire [7:0] i_p0,    // Low address or write data
  input  wire       i_ale,   // Latch strobe
  input  wire       i_rd_n,  // Read strobe
  input  wire       i_wr_n,  // Write strobe
  output wire [7:0] o_p0     // Read data onto port 0
);
  reg [7:0] mem [0:65535];
  reg [7:0] lat_q = 8'h00;
  reg [7:0] last_q = 8'h00;
  always @(negedge i_ale) lat_q <= i_p0;
  always @(posedge i_clock) begin
    if (!i_wr_n) mem[{i_p2, lat_q}] <= i_p0;
    if (!i_rd_n) last_q <= mem[{i_p2, lat_q}];
  end
  // Released bus shows the inverse of the last value, never a stale copy
  assign o_p0 = i_rd_n ? ~last_q : mem[{i_p2, lat_q}];
endmodule // auxc_sram_model

// File: verification/auxc_props.sv
// Port checker for the auxiliary control register
`timescale 1ns/100ps
module auxc_props (
  input wire i_clock, i_rst_n, i_ce, i_fast, i_sfr_wr, i_sfr_rd, o_sfr_hit,
  input wire [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, o_p0_out, o_p2_out,
  input wire i_watchdog_control_reg_idle, i_idle, i_wdt_reset, i_reset_polarity, o_wdt_count_en,
  input wire o_rst_pin_out, o_rst_pin_oe_n, i_xreq, o_xbusy, o_xinternal,
  input wire [15:0] i_xaddr,
  input wire o_p0_oe_n, o_ale, o_rd_n, o_wr_n
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  reg [4:0] m_q;
  reg [4:0] n_q;
  wire [4:0] sl = i_fast ? (m_q[3:2] == 2'h0 ? 5'h01 : m_q[3:2] == 2'h3 ? 5'h03 : 5'h02)
                         : (m_q[2] ? 5'h0f : 5'h03);
  wire fr = !m_q[0] && !o_xbusy && !i_idle;
  always @(posedge i_clock) begin
    if (!i_rst_n) m_q <= 5'h00;
    else if (i_ce && i_sfr_wr && i_sfr_addr == 8'h8e) m_q <= i_sfr_wdata[4:0];
    if (!i_rst_n || (o_rd_n && o_wr_n)) n_q <= 5'h00;
    else n_q <= n_q + 5'h01;
  end
  sequence s_free_fast; (fr && i_fast)[*3]; endsequence
  sequence s_free_cmp; (fr && !i_fast)[*4]; endsequence
  ////////////////////////////////////////////////////////////////////////////////
  chk_hit_decode: assert property (o_sfr_hit == (i_sfr_addr == 8'h8e))
    else $error("hit decode wrong");
  chk_top_bits: assert property (i_ce && i_sfr_rd |=> o_sfr_rdata[7:5] == 3'h0)
    else $error("top bits not zero");
  chk_idle_halt: assert property (o_wdt_count_en ==
    !(i_idle && (i_fast ? i_watchdog_control_reg_idle : m_q[4]))) else $error("count enable wrong");
  chk_reset_drive: assert property (i_ce && i_wdt_reset && !i_fast && !m_q[3]
    |=> !o_rst_pin_oe_n && o_rst_pin_out == $past(i_reset_polarity)) else $error("no drive");
  chk_ale_quiet: assert property (m_q[0] && $past(m_q[0]) && !o_xbusy
    && !$past(o_xbusy) |-> o_ale) else $error("latch strobe not idle high");
  chk_ale_half: assert property (s_free_fast |-> o_ale != $past(o_ale))
    else $error("fast free strobe rate");
  chk_ale_third: assert property (s_free_cmp
    |-> $onehot({o_ale, $past(o_ale), $past(o_ale, 2)})) else $error("compat strobe rate");
  chk_int_map: assert property (o_xinternal ==
    (i_xreq && i_xaddr <= 16'h00ff && !m_q[1])) else $error("internal map wrong");
  chk_int_nobus: assert property (o_xinternal && !o_xbusy |=> !o_xbusy)
    else $error("bus cycle for internal address");
  chk_strobe_len: assert property ($rose(o_rd_n && o_wr_n) |-> n_q == sl)
    else $error("strobe width wrong");
  chk_addr_hold: assert property ($fell(o_ale) && o_xbusy
    |-> $stable(o_p0_out) && $stable(o_p2_out) && !o_p0_oe_n) else $error("address moved");
endmodule // auxc_props
bind auxc_top auxc_props u_props (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_ce(i_ce),
  .i_fast(i_fast), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .o_sfr_hit(o_sfr_hit),
  .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
  .o_p0_out(o_p0_out), .o_p2_out(o_p2_out), .i_watchdog_control_reg_idle(i_watchdog_control_reg_idle), .i_idle(i_idle),
  .i_wdt_reset(i_wdt_reset), .i_reset_polarity(i_reset_polarity),
  .o_wdt_count_en(o_wdt_count_en), .o_rst_pin_out(o_rst_pin_out),
  .o_rst_pin_oe_n(o_rst_pin_oe_n), .i_xreq(i_xreq), .o_xbusy(o_xbusy),
  .o_xinternal(o_xinternal), .i_xaddr(i_xaddr), .o_p0_oe_n(o_p0_oe_n), .o_ale(o_ale),
  .o_rd_n(o_rd_n), .o_wr_n(o_wr_n));

// File: verification/auxc_testbench.sv
// Self-checking bench for the auxiliary control register
`timescale 1ns/100ps
module testbench;
  reg clk = 0, rst_n = 0, fast = 0, wr = 0, rd = 0, idle = 0, wrst = 0, reset_polarity = 0;
  reg widle = 0, xreq = 0, xw = 0;
  reg ce = 1, wrd = 0;
  reg [7:0] a = 8'h00, wd = 8'h00, xd = 8'h00;
  reg [15:0] xa = 16'h0000;
  wire [7:0] rdata, xrd, p2, p0, p0i;
  wire hit, cen, rpo, rpoe, busy, done, xint, p0oe, ale, rdn, wrn;
  integer errors = 0, checks = 0, i, n, k;
  auxc_top dut (.i_clock(clk), .i_rst_n(rst_n), .i_ce(ce), .i_fast(fast),
    .i_sfr_addr(a), .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wd), .o_sfr_rdata(rdata),
    .o_sfr_hit(hit), .i_watchdog_control_reg_idle(widle), .i_watchdog_control_reg_rstdis(wrd), .i_idle(idle),
    .i_wdt_reset(wrst), .i_reset_polarity(reset_polarity), .o_wdt_count_en(cen), .o_rst_pin_out(rpo),
    .o_rst_pin_oe_n(rpoe), .i_xreq(xreq), .i_xwrite(xw), .i_xaddr(xa), .i_xwdata(xd),
    .o_xrdata(xrd), .o_xbusy(busy), .o_xdone(done), .o_xinternal(xint), .o_p2_out(p2),
    .o_p0_out(p0), .o_p0_oe_n(p0oe), .i_p0_in(p0i), .o_ale(ale), .o_rd_n(rdn), .o_wr_n(wrn));
  auxc_sram_model sram (.i_clock(clk), .i_p2(p2), .i_p0(p0), .i_ale(ale), .i_rd_n(rdn),
    .i_wr_n(wrn), .o_p0(p0i));
  initial forever #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input [15:0] g, input [15:0] e); begin
    checks = checks + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  end endtask
  task tick; begin @(posedge clk); #1; end endtask
  task sw(input [7:0] ad, input [7:0] d); begin a = ad; wd = d; wr = 1; tick; wr = 0; end endtask
  task sr(input [7:0] ad, input [7:0] e); begin a = ad; rd = 1; tick; rd = 0; chk(rdata, e); end
  endtask
  // One external move; counts cycles with a strobe low
  task xf(input w, input [15:0] ad, input [7:0] d, input [4:0] sl); begin
    xw = w; xa = ad; xd = d; xreq = 1; tick; xreq = 0; n = 0; k = 0;
    while (done !== 1'b1 && k < 60) begin
      if (rdn === 1'b0 || wrn === 1'b0) n = n + 1;
      tick; k = k + 1;
    end
    chk(done, 1'b1);
    chk(n, sl);
    if (!w) chk(xrd, d);
    tick;
  end endtask
  task tally_and_finish; begin
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  end endtask
  initial begin #300000; errors = errors + 1; tally_and_finish; end
  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1;
    sr(8'h8e, 8'h00);
    tick;
    sr(8'h8f, 8'h00);
    sw(8'h8e, 8'hff);
    sr(8'h8e, 8'h1f);
    rst_n = 0;
    tick;
    tick;
    rst_n = 1;
    sr(8'h8e, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      fast = i < 4;
      sw(8'h8e, i[1:0] << 2);
      n = fast ? (i == 0 ? 1 : i == 3 ? 3 : 2) : (i[0] ? 15 : 3);
      xf(1, 16'h1200 + i, 8'h5a + i, n);
      xf(0, 16'h1200 + i, 8'h5a + i, n);
    end
    fast = 1;
    sw(8'h8e, 8'h00);
    xa = 16'h0010; xreq = 1; #1 chk(xint, 1);
    tick; xreq = 0; chk(busy, 0);
    sw(8'h8e, 8'h02);
    xf(1, 16'h0010, 8'hc3, 1);
    xf(0, 16'h0010, 8'hc3, 1);
    fast = 0; sw(8'h8e, 8'h10); idle = 1; #1 chk(cen, 0);
    fast = 1; #1 chk(cen, 1);
    widle = 1; #1 chk(cen, 0);
    idle = 0; widle = 0; fast = 0; sw(8'h8e, 8'h00);
    reset_polarity = 1; wrst = 1; tick; wrst = 0; chk({rpoe, rpo}, 2'h1);
    sw(8'h8e, 8'h08); wrst = 1; tick; wrst = 0; chk(rpoe, 1);
    fast = 1; sw(8'h8e, 8'h00); wrd = 1; wrst = 1; tick; wrst = 0; chk(rpoe, 1);
    wrd = 0; fast = 0; sw(8'h8e, 8'h01); tick;
    for (i = 0; i < 6; i = i + 1) begin tick; chk(ale, 1); end
    ce = 0; sw(8'h8e, 8'h00); ce = 1; sr(8'h8e, 8'h01);
    for (k = 0; k < 2; k = k + 1) begin
      fast = k; sw(8'h8e, 8'h00); tick; tick; n = 0;
      for (i = 0; i < 12; i = i + 1) begin tick; n = n + ale; end
      chk(n, k ? 6 : 4);
    end
    tally_and_finish;
  end
endmodule // testbench
